// [hdl/fiolc_top.sv]
// Functional notes
// - Transmit multiframe event every 2ms E1, 1.5ms D4 or 3ms ESF.
// - E1: slot 16 all zeros over one whole multiframe sets event.
// - E1: under three zeros in slot 16 over 16 frames sets event.
// - T1: recognised AIS-CI pattern sets its event.
// - Mask register at 1Dh, one bit per event, one enables.
// - Format bit 0 gives bipolar outputs, 1 gives NRZ with negative low outside remote and payload loops.
// - Transmit sync direction and frame or multiframe pulse selection.
// - Double-wide transmit sync in signaling frames; software keeps it legal.
// - Receive sync direction; input only with elastic store enabled.
// - Receive sync selects frame or multiframe pulses.
// - T1: alternate bit doubles receive sync width in signaling frames.
// - E1: alternate bit picks CAS or CRC4 multiframe boundaries.
// - Skip bit pulses receive sync on every other multiframe.
// - Backplane rate bits: 0 for 1.544MHz, 1 for 2.048MHz or interleaved.
// - Sync shift enable bit selects shifted sync timing.
// - Five independent inversion bits for syncs and clocks.
// - Framer loop: transmit to receive, line input ignored, T1 sends ones.
// - Payload loop: transmit on receive timing, transmit payload replaced by receive payload.
// - Payload loop carries corrected payload; overhead regenerated locally.
// - Remote loop: line input retransmitted, formatter output discarded.
// - Local loop: transmitted data replaces receive data via attenuator.
`timescale 1ns/1ns
module fiolc_top (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire fiolc_pkg::fiolc_host_req_s host_req_i,
  input wire fiolc_pkg::fiolc_rx_stat_s rx_stat_i,
  input wire logic tx_pos_i,
  input wire logic tx_neg_i,
  input wire logic tx_nrz_i,
  input wire logic tx_is_payload_i,
  input wire logic line_rx_pos_in_i,
  input wire logic line_rx_neg_in_i,
  input wire logic rx_payload_pos_i,
  input wire logic rx_payload_neg_i,
  input wire logic line_unit_split_pin_i,
  input wire logic tx_sync_pin_i,
  input wire logic tx_sig_frame_i,
  input wire logic rx_sig_frame_i,
  input wire logic rx_crc4_mf_i,
  input wire logic rx_elastic_en_i,
  output logic [7:0] host_rdata_o,
  output logic event_irq_o,
  output logic line_tx_pos_out_o,
  output logic line_tx_neg_out_o,
  output logic rx_data_pos_o,
  output logic rx_data_neg_o,
  output logic rx_from_tx_clock_o,
  output logic tx_from_rx_clock_o,
  output logic line_unit_joined_o,
  output logic jitter_path_loop_o,
  output logic tx_sync_pin_o,
  output logic tx_sync_pin_oe_o,
  output logic rx_sync_pin_o,
  output logic rx_sync_pin_oe_o,
  output logic tx_sys_sync_inv_o,
  output logic rx_clock_inv_o,
  output logic tx_clock_inv_o,
  output logic rx_backplane_rate_o,
  output logic tx_backplane_rate_o,
  output logic sync_shift_o
);
  import fiolc_pkg::*;

  fiolc_io_one_s io_one_reg;
  fiolc_io_two_s io_two_reg;
  fiolc_loop_s loop_reg;
  logic [7:0] mask_reg;
  logic [7:0] status_reg;
  logic [7:0] status_set;
  logic [7:0] rdata_next;
  logic [18:0] tx_mf_cnt_reg;
  logic [18:0] tx_mf_limit;
  logic rx_sig_nonzero_reg;
  logic [4:0] rx_zero_cnt_reg;
  logic [3:0] rx_frame_cnt_reg;
  logic rx_mf_odd_reg;
  logic fs_dly_reg;
  logic [2:0] tx_sync_pin_meta_reg;
  logic tx_sync_in_reg;
  logic host_rd;
  logic host_wr;

  assign host_rd = host_req_i.cs & host_req_i.rd;
  assign host_wr = host_req_i.cs & host_req_i.wr;

  // ==========================================================================
  // Host register writes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_one_reg <= RESET_VALUE;
      io_two_reg <= RESET_VALUE;
      mask_reg <= RESET_VALUE;
      loop_reg <= RESET_VALUE;
    end else if (host_wr) begin
      if (host_req_i.addr == ADDR_IO_CONFIG_ONE) begin
        io_one_reg <= host_req_i.wdata;
      end else if (host_req_i.addr == ADDR_IO_CONFIG_TWO) begin
        io_two_reg <= host_req_i.wdata;
      end else if (host_req_i.addr == ADDR_EVENT_MASK_FOUR) begin
        mask_reg <= host_req_i.wdata;
      end else if (host_req_i.addr == ADDR_LOOPBACK_CONTROL) begin
        loop_reg <= host_req_i.wdata & LOOPBACK_WRITE_MASK;
      end
    end
  end

  // ==========================================================================
  // Transmit multiframe timer
  always_comb begin
    if (rx_stat_i.e1_mode) begin
      tx_mf_limit = 19'(MF_E1_CYC - 1);
    end else if (rx_stat_i.esf_mode) begin
      tx_mf_limit = 19'(MF_ESF_CYC - 1);
    end else begin
      tx_mf_limit = 19'(MF_D4_CYC - 1);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_mf_cnt_reg <= '0;
    end else if (tx_mf_cnt_reg >= tx_mf_limit) begin
      tx_mf_cnt_reg <= '0;
    end else begin
      tx_mf_cnt_reg <= tx_mf_cnt_reg + 19'h00001;
    end
  end

  // ==========================================================================
  // Slot 16 watchers (E1). Zero watch spans one multiframe, ones watch 16 frames.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Starts high: no full multiframe seen yet
      rx_sig_nonzero_reg <= 1'b1;
      rx_zero_cnt_reg <= '0;
      rx_frame_cnt_reg <= '0;
    end else begin
      if (rx_stat_i.mf_start) begin
        rx_sig_nonzero_reg <= rx_stat_i.ts16_valid & rx_stat_i.ts16_bit;
      end else if (rx_stat_i.ts16_valid && rx_stat_i.ts16_bit) begin
        rx_sig_nonzero_reg <= 1'b1;
      end
      if (rx_stat_i.frame_start && rx_frame_cnt_reg == 4'(E1_FRAMES_PER_MF - 1)) begin
        rx_frame_cnt_reg <= '0;
        rx_zero_cnt_reg <= '0;
      end else begin
        if (rx_stat_i.frame_start) begin
          rx_frame_cnt_reg <= rx_frame_cnt_reg + 4'h1;
        end
        if (rx_stat_i.ts16_valid && !rx_stat_i.ts16_bit && rx_zero_cnt_reg != 5'h1f) begin
          rx_zero_cnt_reg <= rx_zero_cnt_reg + 5'h01;
        end
      end
    end
  end

  always_comb begin
    status_set = '0;
    status_set[EV_TX_MF] = (tx_mf_cnt_reg >= tx_mf_limit);
    status_set[EV_RX_SIG_ZERO] = rx_stat_i.e1_mode & rx_stat_i.mf_start & ~rx_sig_nonzero_reg;
    status_set[EV_RX_SIG_ONE] = rx_stat_i.e1_mode & rx_stat_i.frame_start
      & (rx_frame_cnt_reg == 4'(E1_FRAMES_PER_MF - 1))
      & (rx_zero_cnt_reg < 5'(SIG_ONE_ZERO_LIMIT));
    status_set[EV_RX_ALARM_CI] = ~rx_stat_i.e1_mode & rx_stat_i.alarm_ci_seen;
  end

  // Sticky status, cleared by reading; a set in the read cycle wins
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= RESET_VALUE;
    end else if (host_rd && host_req_i.addr == ADDR_EVENT_STATUS_FOUR) begin
      status_reg <= status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_irq_o <= 1'b0;
    end else begin
      event_irq_o <= |((status_reg | status_set) & mask_reg);
    end
  end

  // ==========================================================================
  // Read data
  always_comb begin
    if (host_req_i.addr == ADDR_IO_CONFIG_ONE) begin
      rdata_next = io_one_reg;
    end else if (host_req_i.addr == ADDR_IO_CONFIG_TWO) begin
      rdata_next = io_two_reg;
    end else if (host_req_i.addr == ADDR_EVENT_STATUS_FOUR) begin
      rdata_next = status_reg;
    end else if (host_req_i.addr == ADDR_EVENT_MASK_FOUR) begin
      rdata_next = mask_reg;
    end else if (host_req_i.addr == ADDR_LOOPBACK_CONTROL) begin
      rdata_next = loop_reg;
    end else begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_rdata_o <= '0;
    end else if (host_rd) begin
      host_rdata_o <= rdata_next;
    end
  end

  // ==========================================================================
  // Line data paths and loopbacks
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_tx_pos_out_o <= 1'b0;
      line_tx_neg_out_o <= 1'b0;
      rx_data_pos_o <= 1'b0;
      rx_data_neg_o <= 1'b0;
    end else begin
      if (loop_reg.remote_loop_en) begin
        line_tx_pos_out_o <= line_rx_pos_in_i;
        line_tx_neg_out_o <= line_rx_neg_in_i;
      // T1 framer loop sends unframed ones
      end else if (loop_reg.framer_loop_en && !rx_stat_i.e1_mode) begin
        line_tx_pos_out_o <= 1'b1;
        line_tx_neg_out_o <= ~io_one_reg.line_out_format;
      // payload from receive, overhead from local formatter
      end else if (loop_reg.payload_loop_en && tx_is_payload_i) begin
        line_tx_pos_out_o <= rx_payload_pos_i;
        line_tx_neg_out_o <= rx_payload_neg_i;
      end else if (io_one_reg.line_out_format) begin
        line_tx_pos_out_o <= tx_nrz_i;
        line_tx_neg_out_o <= 1'b0;
      end else begin
        line_tx_pos_out_o <= tx_pos_i;
        line_tx_neg_out_o <= tx_neg_i;
      end
      if (loop_reg.framer_loop_en || loop_reg.local_loop_en) begin
        rx_data_pos_o <= tx_pos_i;
        rx_data_neg_o <= tx_neg_i;
      end else begin
        rx_data_pos_o <= line_rx_pos_in_i;
        rx_data_neg_o <= line_rx_neg_in_i;
      end
    end
  end

  // Clock steering; the caller must not wire rx clock back into tx clock
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_from_tx_clock_o <= 1'b0;
      tx_from_rx_clock_o <= 1'b0;
      line_unit_joined_o <= 1'b0;
      jitter_path_loop_o <= 1'b0;
    end else begin
      rx_from_tx_clock_o <= loop_reg.framer_loop_en;
      // tx and link clock from rx clock
      tx_from_rx_clock_o <= loop_reg.payload_loop_en;
      line_unit_joined_o <= line_unit_split_pin_i & ~loop_reg.line_unit_split_bit;
      jitter_path_loop_o <= loop_reg.local_loop_en;
    end
  end

  // ==========================================================================
  // Sync pins and backplane controls
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sync_pin_meta_reg <= '0;
      tx_sync_in_reg <= 1'b0;
      fs_dly_reg <= 1'b0;
    end else begin
      tx_sync_pin_meta_reg <= {tx_sync_pin_meta_reg[1:0], tx_sync_pin_i};
      // A pin change counts only once the last two stages agree
      if (tx_sync_pin_meta_reg[2] == tx_sync_pin_meta_reg[1]) begin
        tx_sync_in_reg <= tx_sync_pin_meta_reg[2];
      end
      fs_dly_reg <= rx_stat_i.frame_start;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_mf_odd_reg <= 1'b0;
    end else if (rx_stat_i.mf_start) begin
      rx_mf_odd_reg <= ~rx_mf_odd_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sync_pin_o <= 1'b0;
      tx_sync_pin_oe_o <= 1'b0;
      rx_sync_pin_o <= 1'b0;
      rx_sync_pin_oe_o <= 1'b0;
    end else begin
      tx_sync_pin_oe_o <= io_one_reg.tx_sync_dir;
      tx_sync_pin_o <= io_two_reg.tx_sync_invert ^
        (io_one_reg.tx_sync_mf_sel ? (tx_mf_cnt_reg == '0) :
         (rx_stat_i.frame_start | (io_one_reg.tx_sync_double_wide & tx_sig_frame_i
           & tx_sync_in_reg)));
      rx_sync_pin_oe_o <= ~io_one_reg.rx_sync_dir | ~rx_elastic_en_i;
      if (!io_one_reg.rx_sync_mf_sel) begin
        rx_sync_pin_o <= io_two_reg.rx_sync_invert ^ (rx_stat_i.frame_start |
          (!rx_stat_i.e1_mode & io_one_reg.rx_sync_alt_sel & rx_sig_frame_i & fs_dly_reg));
      end else begin
        rx_sync_pin_o <= io_two_reg.rx_sync_invert ^
          ((rx_stat_i.e1_mode && io_one_reg.rx_sync_alt_sel) ? rx_crc4_mf_i :
           (rx_stat_i.mf_start & (~io_one_reg.rx_sync_mf_skip | rx_mf_odd_reg)));
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sys_sync_inv_o <= 1'b0;
      rx_clock_inv_o <= 1'b0;
      tx_clock_inv_o <= 1'b0;
      rx_backplane_rate_o <= 1'b0;
      tx_backplane_rate_o <= 1'b0;
      sync_shift_o <= 1'b0;
    end else begin
      tx_sys_sync_inv_o <= io_two_reg.tx_sys_sync_invert;
      rx_clock_inv_o <= io_two_reg.rx_clock_invert;
      tx_clock_inv_o <= io_two_reg.tx_clock_invert;
      rx_backplane_rate_o <= io_two_reg.rx_backplane_rate_sel;
      tx_backplane_rate_o <= io_two_reg.tx_backplane_rate_sel;
      sync_shift_o <= io_two_reg.sync_shift_en;
    end
  end

endmodule

// [hdl/fiolc_pkg.sv]
package fiolc_pkg;

  // ==========================================================================
  // Register map (parallel port, byte addresses)
  localparam logic [7:0] ADDR_IO_CONFIG_ONE = 8'h01;
  localparam logic [7:0] ADDR_IO_CONFIG_TWO = 8'h02;
  localparam logic [7:0] ADDR_EVENT_STATUS_FOUR = 8'h1c;
  localparam logic [7:0] ADDR_EVENT_MASK_FOUR = 8'h1d;
  localparam logic [7:0] ADDR_LOOPBACK_CONTROL = 8'h4a;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] LOOPBACK_WRITE_MASK = 8'h1f;

  // ==========================================================================
  // Field positions
  localparam int EV_TX_MF = 4;
  localparam int EV_RX_SIG_ZERO = 5;
  localparam int EV_RX_SIG_ONE = 6;
  localparam int EV_RX_ALARM_CI = 7;

  // ==========================================================================
  // Timing: multiframe periods in microseconds, cycle counts at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int MF_E1_US = 2000;
  localparam int MF_D4_US = 1500;
  localparam int MF_ESF_US = 3000;
  localparam int MF_E1_CYC = MF_E1_US * 1000 / CLK_PERIOD_NS;
  localparam int MF_D4_CYC = MF_D4_US * 1000 / CLK_PERIOD_NS;
  localparam int MF_ESF_CYC = MF_ESF_US * 1000 / CLK_PERIOD_NS;
  localparam int E1_FRAMES_PER_MF = 16;
  localparam int SIG_ONE_ZERO_LIMIT = 3;

  typedef struct packed {
    logic rx_sync_mf_skip;
    logic rx_sync_alt_sel;
    logic rx_sync_mf_sel;
    logic rx_sync_dir;
    logic tx_sync_double_wide;
    logic tx_sync_mf_sel;
    logic tx_sync_dir;
    logic line_out_format;
  } fiolc_io_one_s;

  typedef struct packed {
    logic rx_clock_invert;
    logic tx_clock_invert;
    logic rx_sync_invert;
    logic tx_sync_invert;
    logic tx_sys_sync_invert;
    logic sync_shift_en;
    logic tx_backplane_rate_sel;
    logic rx_backplane_rate_sel;
  } fiolc_io_two_s;

  typedef struct packed {
    logic [2:0] unused;
    logic line_unit_split_bit;
    logic local_loop_en;
    logic remote_loop_en;
    logic payload_loop_en;
    logic framer_loop_en;
  } fiolc_loop_s;

  // Host parallel port request
  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fiolc_host_req_s;

  // Receive-side framer status strobes feeding the event logic
  typedef struct packed {
    logic e1_mode;
    logic esf_mode;
    logic ts16_valid;
    logic ts16_bit;
    logic frame_start;
    logic mf_start;
    logic alarm_ci_seen;
  } fiolc_rx_stat_s;

endpackage

// [dv/fiolc_props.sv]
`timescale 1ns/1ns
// ==================================================
// Port checks against a shadow of host writes
module fiolc_props (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire fiolc_pkg::fiolc_host_req_s host_req_i,
  input wire logic line_rx_pos_in_i,
  input wire logic line_unit_split_pin_i,
  input wire logic rx_elastic_en_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic line_tx_pos_out_o,
  input wire logic line_tx_neg_out_o,
  input wire logic rx_from_tx_clock_o,
  input wire logic tx_from_rx_clock_o,
  input wire logic line_unit_joined_o,
  input wire logic jitter_path_loop_o,
  input wire logic tx_sync_pin_oe_o,
  input wire logic rx_sync_pin_oe_o,
  input wire logic tx_sys_sync_inv_o,
  input wire logic rx_clock_inv_o,
  input wire logic tx_clock_inv_o,
  input wire logic rx_backplane_rate_o,
  input wire logic tx_backplane_rate_o,
  input wire logic sync_shift_o
);
  import fiolc_pkg::*;
  logic [7:0] one_reg, two_reg, mask_reg, loop_reg;
  logic [1:0] calm_reg;
  logic wr, rd, mapped;
  assign wr = host_req_i.cs & host_req_i.wr;
  assign rd = host_req_i.cs & host_req_i.rd;
  assign mapped = host_req_i.addr inside {ADDR_IO_CONFIG_ONE, ADDR_IO_CONFIG_TWO,
    ADDR_EVENT_STATUS_FOUR, ADDR_EVENT_MASK_FOUR, ADDR_LOOPBACK_CONTROL};
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      one_reg <= RESET_VALUE;
      two_reg <= RESET_VALUE;
      mask_reg <= RESET_VALUE;
      loop_reg <= RESET_VALUE;
    end else if (wr) begin
      case (host_req_i.addr)
        ADDR_IO_CONFIG_ONE: one_reg <= host_req_i.wdata;
        ADDR_IO_CONFIG_TWO: two_reg <= host_req_i.wdata;
        ADDR_EVENT_MASK_FOUR: mask_reg <= host_req_i.wdata;
        ADDR_LOOPBACK_CONTROL: loop_reg <= host_req_i.wdata & LOOPBACK_WRITE_MASK;
        default: ;
      endcase
    end
  end
  // Outputs trail a write by two edges; three quiet edges leave margin
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i || wr) begin
      calm_reg <= 2'd0;
    end else if (calm_reg != 2'd3) begin
      calm_reg <= calm_reg + 2'd1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_calm;
    calm_reg == 2'd3;
  endsequence
  sequence s_line_held;
    $stable(line_rx_pos_in_i) [*3];
  endsequence
  property p_unmapped; rd && !mapped |=> host_rdata_o == 8'h00; endproperty
  property p_mask_read;
    rd && host_req_i.addr == ADDR_EVENT_MASK_FOUR |=> host_rdata_o == mask_reg;
  endproperty
  property p_format; s_calm ##0 loop_reg[2:0] == 3'h0 && one_reg[0] |-> !line_tx_neg_out_o;
  endproperty
  property p_tx_dir; s_calm |-> tx_sync_pin_oe_o == one_reg[1]; endproperty
  property p_rx_dir;
    $stable(rx_elastic_en_i) [*2] ##0 s_calm |->
      rx_sync_pin_oe_o == !(one_reg[4] && rx_elastic_en_i);
  endproperty
  property p_rates;
    s_calm |-> {sync_shift_o, tx_backplane_rate_o, rx_backplane_rate_o} == two_reg[2:0];
  endproperty
  property p_invert;
    s_calm |-> {rx_clock_inv_o, tx_clock_inv_o, tx_sys_sync_inv_o} ==
      {two_reg[7], two_reg[6], two_reg[3]};
  endproperty
  property p_framer; s_calm |-> rx_from_tx_clock_o == loop_reg[0]; endproperty
  property p_payload; s_calm |-> tx_from_rx_clock_o == loop_reg[1]; endproperty
  property p_remote;
    s_line_held ##0 s_calm ##0 loop_reg[2] |-> line_tx_pos_out_o == line_rx_pos_in_i;
  endproperty
  property p_local; s_calm |-> jitter_path_loop_o == loop_reg[3]; endproperty
  property p_join;
    $stable(line_unit_split_pin_i) [*2] ##0 s_calm |->
      line_unit_joined_o == (line_unit_split_pin_i && !loop_reg[4]);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");
  a_format: assert property (p_format) else $error("nrz negative output high");
  a_tx_dir: assert property (p_tx_dir) else $error("tx sync enable wrong");
  a_rx_dir: assert property (p_rx_dir) else $error("rx sync enable wrong");
  a_rates: assert property (p_rates) else $error("rate or shift wrong");
  a_invert: assert property (p_invert) else $error("invert output wrong");
  a_framer: assert property (p_framer) else $error("framer loop clock wrong");
  a_payload: assert property (p_payload) else $error("payload loop clock wrong");
  a_remote: assert property (p_remote) else $error("remote loop data wrong");
  a_local: assert property (p_local) else $error("local loop path wrong");
  a_join: assert property (p_join) else $error("line unit join wrong");
endmodule

bind fiolc_top fiolc_props fiolc_props_inst (.clock_i, .rst_n_i, .host_req_i,
  .line_rx_pos_in_i, .line_unit_split_pin_i, .rx_elastic_en_i, .host_rdata_o,
  .line_tx_pos_out_o, .line_tx_neg_out_o, .rx_from_tx_clock_o, .tx_from_rx_clock_o,
  .line_unit_joined_o, .jitter_path_loop_o, .tx_sync_pin_oe_o, .rx_sync_pin_oe_o,
  .tx_sys_sync_inv_o, .rx_clock_inv_o, .tx_clock_inv_o, .rx_backplane_rate_o,
  .tx_backplane_rate_o, .sync_shift_o);

// [dv/fiolc_far_model.sv]
`timescale 1ns/1ns
// ==================================================
// Receive framer status source
module fiolc_far_model (
  input wire logic clock_i,
  output fiolc_pkg::fiolc_rx_stat_s rx_stat_o
);
  import fiolc_pkg::*;
  initial rx_stat_o = '0;
  task automatic set_e1(input logic e1);
    @(negedge clock_i);
    rx_stat_o.e1_mode = e1;
  endtask
  task automatic pulse_alarm();
    @(negedge clock_i);
    rx_stat_o.alarm_ci_seen = 1'b1;
    @(negedge clock_i);
    rx_stat_o.alarm_ci_seen = 1'b0;
  endtask
  task automatic pulse_frame(input logic mf);
    @(negedge clock_i);
    rx_stat_o.frame_start = 1'b1;
    rx_stat_o.mf_start = mf;
    @(negedge clock_i);
    rx_stat_o.frame_start = 1'b0;
    rx_stat_o.mf_start = 1'b0;
  endtask
  // Idle slot bit shows the inverse so a stale value never passes
  task automatic send_mf(input logic ts_bit);
    for (int f = 0; f < E1_FRAMES_PER_MF; f++) begin
      pulse_frame(f == 0);
      rx_stat_o.ts16_bit = ts_bit;
      rx_stat_o.ts16_valid = 1'b1;
      repeat (8) @(negedge clock_i);
      rx_stat_o.ts16_valid = 1'b0;
      rx_stat_o.ts16_bit = ~ts_bit;
    end
  endtask
endmodule

// [dv/fiolc_top_tb.sv]
`timescale 1ns/1ns
// ==================================================
// Self-checking bench
module fiolc_top_tb;
  import fiolc_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  fiolc_host_req_s host_req_i = '0;
  fiolc_rx_stat_s rx_stat_i;
  logic tx_pos_i = 1'b0, tx_neg_i = 1'b0, tx_nrz_i = 1'b0, tx_is_payload_i = 1'b0;
  logic line_rx_pos_in_i = 1'b0, line_rx_neg_in_i = 1'b0;
  logic rx_payload_pos_i = 1'b0, rx_payload_neg_i = 1'b0;
  logic line_unit_split_pin_i = 1'b1, rx_elastic_en_i = 1'b0;
  logic tx_sync_pin_i = 1'b0, tx_sig_frame_i = 1'b0, rx_sig_frame_i = 1'b0;
  logic rx_crc4_mf_i = 1'b0;
  logic [7:0] host_rdata_o;
  logic event_irq_o, line_tx_pos_out_o, line_tx_neg_out_o, rx_data_pos_o, rx_data_neg_o;
  logic rx_from_tx_clock_o, tx_from_rx_clock_o, line_unit_joined_o, jitter_path_loop_o;
  logic tx_sync_pin_o, tx_sync_pin_oe_o, rx_sync_pin_o, rx_sync_pin_oe_o, tx_sys_sync_inv_o;
  logic rx_clock_inv_o, tx_clock_inv_o, rx_backplane_rate_o, tx_backplane_rate_o, sync_shift_o;
  int err_count = 0;
  int check_count = 0;
  always #5 clock_i = ~clock_i;
  fiolc_far_model fiolc_far_model_inst (.clock_i, .rx_stat_o(rx_stat_i));
  fiolc_top fiolc_top_inst (.clock_i, .rst_n_i, .host_req_i, .rx_stat_i, .tx_pos_i, .tx_neg_i,
    .tx_nrz_i, .tx_is_payload_i, .line_rx_pos_in_i, .line_rx_neg_in_i, .rx_payload_pos_i,
    .rx_payload_neg_i, .line_unit_split_pin_i, .tx_sync_pin_i, .tx_sig_frame_i,
    .rx_sig_frame_i, .rx_crc4_mf_i, .rx_elastic_en_i, .host_rdata_o, .event_irq_o,
    .line_tx_pos_out_o, .line_tx_neg_out_o, .rx_data_pos_o, .rx_data_neg_o, .rx_from_tx_clock_o,
    .tx_from_rx_clock_o, .line_unit_joined_o, .jitter_path_loop_o, .tx_sync_pin_o,
    .tx_sync_pin_oe_o, .rx_sync_pin_o, .rx_sync_pin_oe_o, .tx_sys_sync_inv_o, .rx_clock_inv_o,
    .tx_clock_inv_o, .rx_backplane_rate_o, .tx_backplane_rate_o, .sync_shift_o);
  // ==================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (4) @(negedge clock_i);
  endtask
  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    host_req_i = '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock_i);
    host_req_i = '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_i);
    host_req_i = '{cs: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock_i);
    host_req_i = '0;
    @(negedge clock_i);
    check(host_rdata_o, exp);
  endtask
  task automatic lcheck(input logic [1:0] exp);
    settle();
    check({6'h0, line_tx_pos_out_o, line_tx_neg_out_o}, {6'h0, exp});
  endtask
  // ==================================================
  // Scenarios
  task automatic test_regs;
    logic [7:0] adr [5] = '{ADDR_IO_CONFIG_ONE, ADDR_IO_CONFIG_TWO, ADDR_EVENT_MASK_FOUR,
      ADDR_LOOPBACK_CONTROL, ADDR_EVENT_STATUS_FOUR};
    logic [7:0] wv [5] = '{8'h46, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] kv [5] = '{8'h46, 8'hff, 8'hff, 8'h1f, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd_chk(adr[i], RESET_VALUE);
      host_wr(adr[i], wv[i]);
      rd_chk(adr[i], kv[i]);
      host_wr(adr[i], 8'h00);
    end
    host_wr(8'h03, 8'h5a);
    rd_chk(8'h03, 8'h00);
  endtask
  task automatic test_config;
    logic [7:0] v;
    {tx_pos_i, tx_neg_i, tx_nrz_i} = 3'b011;
    host_wr(ADDR_IO_CONFIG_ONE, 8'h03);
    settle();
    check({4'h0, line_tx_pos_out_o, line_tx_neg_out_o, tx_sync_pin_oe_o, rx_sync_pin_oe_o},
      8'h0b);
    host_wr(ADDR_IO_CONFIG_ONE, 8'h00);
    rx_elastic_en_i = 1'b1;
    host_wr(ADDR_IO_CONFIG_ONE, 8'h10);
    settle();
    check({4'h0, line_tx_pos_out_o, line_tx_neg_out_o, tx_sync_pin_oe_o, rx_sync_pin_oe_o},
      8'h04);
    host_wr(ADDR_IO_CONFIG_ONE, 8'h00);
    rx_elastic_en_i = 1'b0;
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h36 : 8'hc9;
      host_wr(ADDR_IO_CONFIG_TWO, v);
      settle();
      check({2'h0, rx_clock_inv_o, tx_clock_inv_o, tx_sys_sync_inv_o, sync_shift_o,
        tx_backplane_rate_o, rx_backplane_rate_o}, {2'h0, v[7], v[6], v[3:0]});
    end
    host_wr(ADDR_IO_CONFIG_TWO, 8'h00);
  endtask
  task automatic test_loops;
    fiolc_far_model_inst.set_e1(1'b1);
    {tx_pos_i, tx_neg_i, line_rx_pos_in_i, line_rx_neg_in_i} = 4'b1001;
    {tx_is_payload_i, rx_payload_pos_i, rx_payload_neg_i} = 3'b110;
    host_wr(ADDR_LOOPBACK_CONTROL, 8'h04);
    lcheck(2'b01);
    {tx_pos_i, tx_neg_i, line_rx_pos_in_i, line_rx_neg_in_i} = 4'b0110;
    lcheck(2'b10);
    host_wr(ADDR_LOOPBACK_CONTROL, 8'h01);
    lcheck(2'b01);
    check({6'h0, rx_data_pos_o, rx_from_tx_clock_o}, 8'h01);
    host_wr(ADDR_LOOPBACK_CONTROL, 8'h02);
    lcheck(2'b10);
    check({7'h0, tx_from_rx_clock_o}, 8'h01);
    host_wr(ADDR_LOOPBACK_CONTROL, 8'h08);
    lcheck(2'b01);
    check({6'h0, jitter_path_loop_o, line_unit_joined_o}, 8'h03);
    host_wr(ADDR_LOOPBACK_CONTROL, 8'h18);
    settle();
    check({6'h0, jitter_path_loop_o, line_unit_joined_o}, 8'h02);
    host_wr(ADDR_LOOPBACK_CONTROL, 8'h08);
    line_unit_split_pin_i = 1'b0;
    settle();
    check({6'h0, jitter_path_loop_o, line_unit_joined_o}, 8'h02);
    line_unit_split_pin_i = 1'b1;
    host_wr(ADDR_LOOPBACK_CONTROL, 8'h00);
  endtask
  task automatic test_events;
    fiolc_far_model_inst.send_mf(1'b1);
    fiolc_far_model_inst.send_mf(1'b1);
    host_wr(ADDR_EVENT_MASK_FOUR, 8'h00);
    rd_chk(ADDR_EVENT_STATUS_FOUR, 8'h40);
    fiolc_far_model_inst.send_mf(1'b1);
    fiolc_far_model_inst.send_mf(1'b1);
    rd_chk(ADDR_EVENT_STATUS_FOUR, 8'h40);
    rd_chk(ADDR_EVENT_STATUS_FOUR, 8'h00);
    fiolc_far_model_inst.send_mf(1'b0);
    fiolc_far_model_inst.send_mf(1'b0);
    rd_chk(ADDR_EVENT_STATUS_FOUR, 8'h20);
    fiolc_far_model_inst.set_e1(1'b0);
    fiolc_far_model_inst.pulse_alarm();
    settle();
    check({7'h0, event_irq_o}, 8'h00);
    host_wr(ADDR_EVENT_MASK_FOUR, 8'h80);
    settle();
    check({7'h0, event_irq_o}, 8'h01);
    rd_chk(ADDR_EVENT_STATUS_FOUR, 8'h80);
    settle();
    check({7'h0, event_irq_o}, 8'h00);
  endtask
  task automatic test_sync;
    host_wr(ADDR_IO_CONFIG_ONE, 8'h4a);
    rx_sig_frame_i = 1'b1;
    fiolc_far_model_inst.pulse_frame(1'b0);
    check({6'h0, rx_sync_pin_o, tx_sync_pin_o}, 8'h03);
    @(negedge clock_i);
    check({6'h0, rx_sync_pin_o, tx_sync_pin_o}, 8'h02);
    @(negedge clock_i);
    check({6'h0, rx_sync_pin_o, tx_sync_pin_o}, 8'h00);
    {tx_sig_frame_i, tx_sync_pin_i} = 2'b11;
    repeat (2) settle();
    check({6'h0, rx_sync_pin_o, tx_sync_pin_o}, 8'h01);
    fiolc_far_model_inst.set_e1(1'b1);
    host_wr(ADDR_IO_CONFIG_ONE, 8'h60);
    for (int i = 0; i < 2; i++) begin
      rx_crc4_mf_i = (i == 0);
      fiolc_far_model_inst.pulse_frame(1'b1);
      check(8'(rx_sync_pin_o), i ? 8'h00 : 8'h01);
    end
  endtask
  // ==================================================
  // Main sequence and watchdog; tests need about 1200 cycles
  initial begin
    repeat (8) @(negedge clock_i);
    rst_n_i = 1'b1;
    test_regs();
    test_config();
    test_loops();
    test_events();
    test_sync();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    err_count++;
    summarize();
  end
endmodule
